// ===== core/bkis_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the brake interlock sequencer.
// Assumes a 50 MHz pclk and byte addresses on an 8-bit APB paddr.
// Function
// - Brake release output low releases, high holds; routed to out_term it is high to release
// - Terminal selection zero drives no terminal
// - Selection 1 to 6 routes to terminal 1 to 6
// - Shared terminal outputs the OR of functions
// - Standstill servo off engages brake same cycle
// - Alarm removes motor current immediately
// - Stopping below speed level engages brake
// - Stopping past wait time engages brake
// - Speed or time, whichever first, engages brake
// - Stop method: 0 reverse braking, 1 coasting
// - Reverse braking uses emergency torque limit
// - Stop method applies at servo off only
// - Power loss forces reverse braking stop
// - Alarm forces coasting stop
// - Emergency torque limit 0 to 300, default 300
`ifndef BKIS_REGS_SVH
`define BKIS_REGS_SVH

// ==========================================================
// Register offsets
`define BKIS_OFF_CTRL      8'h00
`define BKIS_OFF_SPEED     8'h04
`define BKIS_OFF_WAIT      8'h08
`define BKIS_OFF_TRQ       8'h0C
`define BKIS_OFF_STATUS    8'h10
`define BKIS_OFF_IRQ_STAT  8'h14
`define BKIS_OFF_IRQ_MASK  8'h18

// ==========================================================
// Field positions
`define BKIS_CTRL_STOP_BIT 0
`define BKIS_CTRL_SEL_LSB  4
`define BKIS_IRQ_ALARM     0
`define BKIS_IRQ_PWR       1
`define BKIS_IRQ_BRAKE     2
`define BKIS_IRQ_DONE      3

// ==========================================================
// Reset values and ranges
`define BKIS_RST_SPEED     13'h0064
`define BKIS_MAX_SPEED     13'h1770
`define BKIS_RST_WAIT      7'h32
`define BKIS_MIN_WAIT      7'h0A
`define BKIS_MAX_WAIT      7'h64
`define BKIS_RST_TRQ       9'h12C
`define BKIS_MAX_TRQ       9'h12C
`define BKIS_RST_SEL       3'h0
`define BKIS_RST_MASK      4'h0

// ==========================================================
// Timing
`define BKIS_CLK_KHZ       50000
`define BKIS_WAIT_UNIT_MS  10
`define BKIS_TICK_CYC      (`BKIS_WAIT_UNIT_MS * `BKIS_CLK_KHZ)

`endif

// ===== core/bkis_pkg.sv
// Types shared by the brake interlock sequencer modules.
// Assumes bkis_regs.svh supplies the numeric constants.
package bkis_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_OFF,
      ST_RUN,
      ST_REV,
      ST_COAST
   } bkis_state_t;

   // ==========================================================
   // Software configuration
   typedef struct packed {
      logic        stop_coast;
      logic [2:0]  term_sel;
      logic [12:0] speed_lvl;
      logic [6:0]  wait_units;
      logic [8:0]  estop_trq;
   } bkis_cfg_t;

   // ==========================================================
   // Commands toward the power stage
   typedef struct packed {
      logic        power_en;
      logic        rev_brake;
      logic        coast;
      logic [8:0]  trq_lim;
   } bkis_drv_t;

endpackage

// ===== core/bkis_wait_timer.sv
// Servo-off wait timer counting 10 ms units.
// Assumes run comes from synchronised logic on pclk.
`timescale 1ns/100ps
`include "bkis_regs.svh"

module bkis_wait_timer
   import bkis_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `BKIS_TICK_CYC
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       run,
   input  wire logic [6:0] wait_units,
   // Result
   output logic            expired
);

   localparam int PW = $clog2(TICK_CYCLES + 1);

   logic [PW-1:0] pre_r;
   logic [PW-1:0] pre_nxt;
   logic [6:0]    units_r;
   logic [6:0]    units_nxt;
   wire           pre_wrap;

   // ==========================================================
   // Prescaler and unit counter
   assign pre_wrap  = (pre_r == PW'(TICK_CYCLES - 1));
   assign pre_nxt   = (!run || pre_wrap) ? '0 : pre_r + 1'b1;
   assign units_nxt = !run ? 7'h00 :
                      (pre_wrap && units_r != 7'h7F) ? units_r + 7'h01 :
                      units_r;
   assign expired   = (units_r > wait_units);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r   <= '0;
         units_r <= 7'h00;
      end else begin
         pre_r   <= pre_nxt;
         units_r <= units_nxt;
      end
   end

   // ==========================================================
   // Checks
   a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> (units_r == 7'h00) && (pre_r == '0))
      else $error("Wait timer not cleared while servo on");

endmodule

// ===== core/bkis_out_router.sv
// Routes the brake release function to one of six output terminals,
// OR-combined with the other functions mapped there.
// Assumes brake_on and other_func come from logic on pclk.
`timescale 1ns/100ps
`include "bkis_regs.svh"

module bkis_out_router
   import bkis_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Functions
   input  wire logic       brake_on,
   input  wire logic [2:0] term_sel,
   input  wire logic [5:0] other_func,
   // Terminals
   output logic [5:0]      out_term
);

   logic [5:0] term_nxt;

   // ==========================================================
   // Per-terminal OR of mapped functions
   for (genvar i = 0; i < 6; i++) begin : g_term
      assign term_nxt[i] = other_func[i] |
                           (brake_on && term_sel == 3'(i + 1));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_term <= 6'h00;
      end else begin
         out_term <= term_nxt;
      end
   end

   // ==========================================================
   // Checks
   a_route_none_off: assert property (@(posedge pclk) disable iff (!presetn)
      term_sel == 3'h0 |=> out_term == $past(other_func))
      else $error("Brake drives a terminal while unassigned");

   a_route_or_mix: assert property (@(posedge pclk) disable iff (!presetn)
      (term_sel == 3'h3) && (brake_on || other_func[2])
      |=> out_term[2])
      else $error("Shared terminal is not the OR of functions");

endmodule

// ===== core/bkis_sequencer.sv
// Brake interlock and stop-method sequencer for one servo axis,
// with its APB register file and interrupt.
// Assumes pin inputs are asynchronous; motor_speed and other_func
// come from logic on pclk.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "bkis_regs.svh"

module bkis_sequencer
   import bkis_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `BKIS_TICK_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        servo_on_n,
   input  wire logic        alarm,
   input  wire logic        main_pwr_ok,
   input  wire logic        ctrl_pwr_ok,
   // Drive logic
   input  wire logic [12:0] motor_speed,
   input  wire logic [5:0]  other_func,
   // Outputs
   output logic             brake_release_n,
   output logic [5:0]       out_term,
   output bkis_drv_t        drive,
   output logic             irq
);

   // ==========================================================
   // Declarations
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   bkis_state_t state_r;
   bkis_state_t state_nxt;
   bkis_cfg_t   cfg_r;
   bkis_cfg_t   cfg_nxt;
   bkis_drv_t   drv_r;
   bkis_drv_t   drv_nxt;
   logic        brake_n_r;
   logic        brake_n_nxt;
   logic [3:0]  irq_stat_r;
   logic [3:0]  irq_stat_nxt;
   logic [3:0]  irq_mask_r;
   logic [3:0]  irq_mask_nxt;
   logic [3:0]  events;
   logic [31:0] prdata_r;
   logic [31:0] rd_mux;
   wire         srv_on;
   wire         alarm_s;
   wire         pwr_lost;
   wire         speed_low;
   wire         motor_stopped;
   wire         tmr_expired;
   wire         stopping_nxt;
   wire         sel_ctrl;
   wire         sel_speed;
   wire         sel_wait;
   wire         sel_trq;
   wire         sel_status;
   wire         sel_istat;
   wire         sel_imask;
   wire         addr_ok;
   wire         wr_acc;
   wire         rd_setup;

   // ==========================================================
   // Helper functions
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [6:0] clamp_wait(input logic [6:0] v);
      return (v < `BKIS_MIN_WAIT) ? `BKIS_MIN_WAIT :
             (v > `BKIS_MAX_WAIT) ? `BKIS_MAX_WAIT : v;
   endfunction

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {ctrl_pwr_ok, main_pwr_ok, alarm, ~servo_on_n};
         sync2_r <= sync1_r;
      end
   end

   assign srv_on        = sync2_r[0];
   assign alarm_s       = sync2_r[1];
   assign pwr_lost      = ~sync2_r[2] | ~sync2_r[3];
   assign speed_low     = motor_speed < cfg_r.speed_lvl;
   assign motor_stopped = (motor_speed == 13'h0000);

   // ==========================================================
   // Stop sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: begin
            if (srv_on && !alarm_s && !pwr_lost) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (alarm_s) begin
               state_nxt = ST_COAST;
            end else if (pwr_lost) begin
               state_nxt = ST_REV;
            end else if (!srv_on) begin
               state_nxt = cfg_r.stop_coast ? ST_COAST : ST_REV;
            end
         end
         ST_REV, ST_COAST: begin
            if (motor_stopped) begin
               state_nxt = ST_OFF;
            end else if (alarm_s) begin
               state_nxt = ST_COAST;
            end
         end
      endcase
   end

   assign stopping_nxt = (state_nxt == ST_REV) || (state_nxt == ST_COAST);

   // Brake engages on the first of speed level and wait time
   assign brake_n_nxt = (state_nxt == ST_RUN) ? 1'b0 :
                        !stopping_nxt ? 1'b1 :
                        (brake_n_r | speed_low | tmr_expired);

   always_comb begin
      drv_nxt           = '0;
      drv_nxt.power_en  = (state_nxt == ST_RUN) ||
                          (state_nxt == ST_REV && !alarm_s);
      drv_nxt.rev_brake = (state_nxt == ST_REV);
      drv_nxt.coast     = (state_nxt == ST_COAST);
      drv_nxt.trq_lim   = (state_nxt == ST_REV) ? cfg_r.estop_trq
                                                 : 9'h000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= ST_OFF;
         brake_n_r <= 1'b1;
         drv_r     <= '0;
      end else begin
         state_r   <= state_nxt;
         brake_n_r <= brake_n_nxt;
         drv_r     <= drv_nxt;
      end
   end

   assign brake_release_n = brake_n_r;
   assign drive           = drv_r;

   // ==========================================================
   // Wait timer and terminal routing
   bkis_wait_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .run        (~srv_on),
      .wait_units (cfg_r.wait_units),
      .expired    (tmr_expired)
   );

   bkis_out_router u_router (
      .pclk       (pclk),
      .presetn    (presetn),
      .brake_on   (~brake_n_nxt),
      .term_sel   (cfg_r.term_sel),
      .other_func (other_func),
      .out_term   (out_term)
   );

   // ==========================================================
   // APB decode
   assign sel_ctrl   = hit(paddr, `BKIS_OFF_CTRL);
   assign sel_speed  = hit(paddr, `BKIS_OFF_SPEED);
   assign sel_wait   = hit(paddr, `BKIS_OFF_WAIT);
   assign sel_trq    = hit(paddr, `BKIS_OFF_TRQ);
   assign sel_status = hit(paddr, `BKIS_OFF_STATUS);
   assign sel_istat  = hit(paddr, `BKIS_OFF_IRQ_STAT);
   assign sel_imask  = hit(paddr, `BKIS_OFF_IRQ_MASK);
   assign addr_ok    = sel_ctrl | sel_speed | sel_wait | sel_trq |
                       sel_status | sel_istat | sel_imask;
   assign wr_acc     = psel & penable & pwrite & addr_ok;
   assign rd_setup   = psel & ~penable & ~pwrite;
   assign pready     = 1'b1;
   assign pslverr    = psel & penable & ~addr_ok;

   // ==========================================================
   // Configuration writes
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_acc && sel_ctrl) begin
         cfg_nxt.stop_coast = pwdata[`BKIS_CTRL_STOP_BIT];
         cfg_nxt.term_sel   = pwdata[`BKIS_CTRL_SEL_LSB +: 3];
      end
      if (wr_acc && sel_speed) begin
         cfg_nxt.speed_lvl = (pwdata[12:0] > `BKIS_MAX_SPEED) ?
                             `BKIS_MAX_SPEED : pwdata[12:0];
      end
      if (wr_acc && sel_wait) begin
         cfg_nxt.wait_units = clamp_wait(pwdata[6:0]);
      end
      if (wr_acc && sel_trq) begin
         cfg_nxt.estop_trq = (pwdata[8:0] > `BKIS_MAX_TRQ) ?
                             `BKIS_MAX_TRQ : pwdata[8:0];
      end
   end

   // ==========================================================
   // Interrupts
   assign events[`BKIS_IRQ_ALARM] = (state_nxt == ST_COAST) &&
                                    (state_r != ST_COAST) && alarm_s;
   assign events[`BKIS_IRQ_PWR]   = (state_nxt == ST_REV) &&
                                    (state_r != ST_REV) && pwr_lost;
   assign events[`BKIS_IRQ_BRAKE] = brake_n_nxt & ~brake_n_r;
   assign events[`BKIS_IRQ_DONE]  = (state_nxt == ST_OFF) &&
                                    (state_r == ST_REV ||
                                     state_r == ST_COAST);

   // Set wins over a write-one clear in the same cycle
   assign irq_stat_nxt = (irq_stat_r &
                          ~((wr_acc && sel_istat) ? pwdata[3:0] : 4'h0))
                         | events;
   assign irq_mask_nxt = (wr_acc && sel_imask) ? pwdata[3:0] : irq_mask_r;
   assign irq          = |(irq_stat_r & irq_mask_r);

   // ==========================================================
   // Read data
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux[`BKIS_CTRL_STOP_BIT]      = cfg_r.stop_coast;
         rd_mux[`BKIS_CTRL_SEL_LSB +: 3]  = cfg_r.term_sel;
      end
      if (sel_speed) begin
         rd_mux[12:0] = cfg_r.speed_lvl;
      end
      if (sel_wait) begin
         rd_mux[6:0] = cfg_r.wait_units;
      end
      if (sel_trq) begin
         rd_mux[8:0] = cfg_r.estop_trq;
      end
      if (sel_status) begin
         rd_mux[5:0] = {srv_on, drv_r.power_en, tmr_expired,
                        brake_n_r, state_r};
      end
      if (sel_istat) begin
         rd_mux[3:0] = irq_stat_r;
      end
      if (sel_imask) begin
         rd_mux[3:0] = irq_mask_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r      <= {1'b0, `BKIS_RST_SEL, `BKIS_RST_SPEED,
                        `BKIS_RST_WAIT, `BKIS_RST_TRQ};
         irq_stat_r <= 4'h0;
         irq_mask_r <= `BKIS_RST_MASK;
         prdata_r   <= 32'h0000_0000;
      end else begin
         cfg_r      <= cfg_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         if (rd_setup) begin
            prdata_r <= rd_mux;
         end
      end
   end

   assign prdata = prdata_r;

   // ==========================================================
   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_run_servo_off;
      state_r == ST_RUN && !srv_on && !alarm_s && !pwr_lost;
   endsequence
   sequence s_stopping;
      state_r == ST_REV || state_r == ST_COAST;
   endsequence
   a_run_release_low: assert property (
      state_r == ST_RUN |-> !brake_release_n)
      else $error("Brake not released while running");
   a_standstill_brake: assert property (
      s_run_servo_off ##0 speed_low |=> brake_release_n)
      else $error("Brake not engaged at standstill servo off");
   a_alarm_cuts_power: assert property (
      alarm_s |=> !drive.power_en)
      else $error("Motor current kept during alarm");
   a_speed_brake_hold: assert property (
      s_stopping ##0 speed_low && !motor_stopped && !srv_on
      |=> brake_release_n)
      else $error("Brake not engaged below speed level");
   a_timeout_brake: assert property (
      s_stopping ##0 tmr_expired |=> brake_release_n)
      else $error("Brake not engaged after wait time");
   a_method_select: assert property (
      s_run_servo_off |=>
      state_r == ($past(cfg_r.stop_coast) ? ST_COAST : ST_REV))
      else $error("Servo off stop method not followed");
   a_rev_torque_lim: assert property (
      drive.rev_brake |-> drive.trq_lim == $past(cfg_r.estop_trq)
                          && drive.trq_lim <= `BKIS_MAX_TRQ)
      else $error("Reverse braking without emergency torque");
   a_power_loss_rev: assert property (
      state_r == ST_RUN && pwr_lost && !alarm_s
      |=> state_r == ST_REV ##1
          (state_r != ST_COAST || $past(alarm_s)))
      else $error("Power loss did not force reverse braking");
   a_alarm_coast: assert property (
      state_r != ST_OFF && alarm_s && !motor_stopped
      |=> state_r == ST_COAST && !drive.power_en)
      else $error("Alarm did not force coasting stop");
   a_reset_hold: assert property (
      state_r == ST_OFF |-> brake_release_n)
      else $error("Brake released while servo disabled");
endmodule

// ===== verification/bkis_motor_model.sv
// Motor model: speed follows the command while powered and not reverse
// braking, runs down otherwise. Assumes drive comes from the sequencer on pclk.
`timescale 1ns/100ps

module bkis_motor_model
   import bkis_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Commands
   input  wire bkis_drv_t   drive,
   input  wire logic [12:0] cmd_speed,
   // Feedback
   output logic [12:0]      motor_speed
);
   // ==========================================================
   // Deceleration
   logic [12:0] step;

   assign step = drive.rev_brake ? 13'h0028 : 13'h0004;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_speed <= 13'h0000;
      end else if (drive.power_en && !drive.rev_brake) begin
         motor_speed <= cmd_speed;
      end else if (motor_speed > step) begin
         motor_speed <= motor_speed - step;
      end else begin
         motor_speed <= 13'h0000;
      end
   end
endmodule

// ===== verification/bkis_testbench.sv
// Self-checking bench for the brake interlock sequencer.
// Assumes the core package, header and the motor model are compiled.
`timescale 1ns/100ps
`include "bkis_regs.svh"

module testbench
   import bkis_pkg::*;
;
   // ==========================================================
   // Signals
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        servo_on_n, alarm, main_pwr_ok, ctrl_pwr_ok;
   logic        brake_release_n, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] motor_speed, cmd_speed;
   logic [5:0]  other_func, out_term;
   bkis_drv_t   drive;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          n;

   always #10 pclk = ~pclk;

   // ==========================================================
   // Instances
   bkis_sequencer #(.TICK_CYCLES(10)) bkis_sequencer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .servo_on_n(servo_on_n),
      .alarm(alarm), .main_pwr_ok(main_pwr_ok),
      .ctrl_pwr_ok(ctrl_pwr_ok), .motor_speed(motor_speed),
      .other_func(other_func), .brake_release_n(brake_release_n),
      .out_term(out_term), .drive(drive), .irq(irq));

   bkis_motor_model bkis_motor_model_inst (
      .pclk(pclk), .presetn(presetn), .drive(drive),
      .cmd_speed(cmd_speed), .motor_speed(motor_speed));

   // ==========================================================
   // Tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task brake_wait(input logic v);
      n = 0;
      while (brake_release_n !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task run_up(input logic [12:0] s);
      cmd_speed <= s;
      servo_on_n <= 1'b0;
      brake_wait(1'b0);
      chk(brake_release_n, 1'b0);
      repeat (4) @(posedge pclk);
   endtask

   task park;
      servo_on_n <= 1'b1;
      for (int i = 0; i < 3000 && motor_speed !== 13'h0000; i++)
         @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask

   // ==========================================================
   // Timeout
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out;
      end
   end

   // ==========================================================
   // Tests
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      servo_on_n = 1'b1;
      alarm = 1'b0;
      main_pwr_ok = 1'b1;
      ctrl_pwr_ok = 1'b1;
      cmd_speed = 13'h0000;
      other_func = 6'h00;
      repeat (8) @(posedge pclk);
      chk(brake_release_n, 1'b1);
      chk(out_term, 6'h00);
      presetn <= 1'b1;
      apb(1'b0, `BKIS_OFF_SPEED, 32'h00000000);
      chk(rd, 32'h00000064);
      apb(1'b0, `BKIS_OFF_WAIT, 32'h00000000);
      chk(rd, 32'h00000032);
      apb(1'b0, `BKIS_OFF_TRQ, 32'h00000000);
      chk(rd, 32'h0000012C);
      apb(1'b0, `BKIS_OFF_CTRL, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b0, 8'h1C, 32'h00000000);
      chk({rd[30:0], err}, 32'h00000001);
      chk(brake_release_n, 1'b1);
      // Terminal routing with the brake released
      run_up(13'h0000);
      chk(brake_release_n, 1'b0);
      for (int s = 0; s < 7; s++) begin
         apb(1'b1, `BKIS_OFF_CTRL, 32'(s) << 4);
         repeat (3) @(posedge pclk);
         chk(out_term, (s == 0) ? 6'h00 : 6'h01 << (s - 1));
      end
      other_func <= 6'h05;
      repeat (3) @(posedge pclk);
      chk(out_term, 32'h00000025);
      // Standstill servo off
      servo_on_n <= 1'b1;
      brake_wait(1'b1);
      chk(n <= 5, 1'b1);
      repeat (4) @(posedge pclk);
      chk(out_term, 32'h00000005);
      chk(drive.power_en, 1'b0);
      // Reverse braking, speed level reached first
      apb(1'b1, `BKIS_OFF_WAIT, 32'h00000064);
      apb(1'b1, `BKIS_OFF_CTRL, 32'h00000000);
      run_up(13'h0BB8);
      servo_on_n <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(drive.rev_brake, 1'b1);
      chk(drive.trq_lim, 9'h12C);
      chk(brake_release_n, 1'b0);
      brake_wait(1'b1);
      chk(n < 200, 1'b1);
      chk(motor_speed < 13'h0064, 1'b1);
      park;
      chk(drive.power_en, 1'b0);
      // Coasting, wait time reached first
      apb(1'b1, `BKIS_OFF_WAIT, 32'h0000000A);
      apb(1'b1, `BKIS_OFF_CTRL, 32'h00000001);
      run_up(13'h0BB8);
      servo_on_n <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(drive.coast, 1'b1);
      brake_wait(1'b1);
      chk(n > 85 && n < 130, 1'b1);
      chk(motor_speed > 13'h0064, 1'b1);
      park;
      // Alarm while running with reverse method, interrupt path
      apb(1'b1, `BKIS_OFF_CTRL, 32'h00000000);
      apb(1'b1, `BKIS_OFF_IRQ_STAT, 32'h0000000F);
      run_up(13'h0BB8);
      alarm <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(drive.power_en, 1'b0);
      chk(drive.coast, 1'b1);
      chk(irq, 1'b0);
      apb(1'b0, `BKIS_OFF_IRQ_STAT, 32'h00000000);
      chk(rd[`BKIS_IRQ_ALARM], 1'b1);
      apb(1'b1, `BKIS_OFF_IRQ_MASK, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      alarm <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, `BKIS_OFF_IRQ_STAT, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      park;
      // Power loss overrides the coasting method
      apb(1'b1, `BKIS_OFF_CTRL, 32'h00000001);
      for (int p = 0; p < 2; p++) begin
         run_up(13'h0BB8);
         if (p == 0) begin
            main_pwr_ok <= 1'b0;
         end else begin
            ctrl_pwr_ok <= 1'b0;
         end
         repeat (5) @(posedge pclk);
         chk(drive.rev_brake, 1'b1);
         chk(drive.coast, 1'b0);
         main_pwr_ok <= 1'b1;
         ctrl_pwr_ok <= 1'b1;
         park;
      end
      apb(1'b0, `BKIS_OFF_IRQ_STAT, 32'h00000000);
      chk(rd, 32'h0000000E);
      close_out;
   end
endmodule
